// [hpp_cfg.svh]
`ifndef HPP_CFG_SVH
`define HPP_CFG_SVH
// address of the final-location data register in 64-bit mode
`define HPP_LAST_ADDR 4'h7
// byte order control values
`define HPP_LITTLE_END 1'b0
`define HPP_BIG_END 1'b1
// receive/transmit word selected as the final location
`define HPP_WORD_ZERO 2'h0
`define HPP_WORD_THREE 2'h3
// request deassertion delay after strobe end, in core periods: 2.5 Tc + 3.3 ns
`define HPP_CLK_PS 5000
`define HPP_DEASSERT_MAX_PS 15800
`define HPP_DEASSERT_CYC ((`HPP_DEASSERT_MAX_PS) / (`HPP_CLK_PS))
// reassertion least delay: 2.5 Tc + 3.3 ns, rounded up
`define HPP_REASSERT_MIN_PS 15800
`define HPP_REASSERT_CYC (((`HPP_REASSERT_MIN_PS) + (`HPP_CLK_PS) - 1) / (`HPP_CLK_PS))
`define HPP_CNT_W 3
`endif

// [hpp_pkg.sv]
package hpp_pkg;
  // request line state for the host dma handshake
  typedef enum logic [1:0] {
    HPP_DMA_IDLE,
    HPP_DMA_REQ,
    HPP_DMA_BUSY,
    HPP_DMA_GAP
  } hpp_dma_e;
endpackage

// [hpp_sync.sv]
`timescale 1ns/1ps
// two-flop synchroniser, one per bit
module hpp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  // first stage is read only by the second
  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule

// [hpp_port.sv]
`timescale 1ns/1ps
`include "hpp_cfg.svh"
module hpp_port #(
  parameter int ADDR_W = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic host_read_strobe,
  input wire logic host_write_strobe,
  input wire logic shared_data_strobe,
  input wire logic read_write_select,
  input wire logic [1:0] port_chip_selects,
  input wire logic [ADDR_W-1:0] port_address_lines,
  input wire logic dma_acknowledge,
  input wire logic pol_strobe_high,
  input wire logic pol_select_high,
  input wire logic pol_ack_high,
  input wire logic pol_request_high,
  input wire logic dual_strobe_mode,
  input wire logic double_request_mode,
  input wire logic mode_64bit,
  input wire logic byte_order_select,
  input wire logic dma_mode,
  input wire logic ack_qualifier_select,
  input wire logic rx_data_ready,
  input wire logic tx_space_ready,
  input wire logic outgoing_fifo_empty,
  input wire logic incoming_fifo_full,
  output logic combined_request,
  output logic receive_request,
  output logic transmit_request,
  output logic [1:0] last_word_index,
  output logic last_read_done,
  output logic last_write_done
);
  localparam int CNT_W = `HPP_CNT_W;
  localparam logic [CNT_W-1:0] DEASSERT_CYC = CNT_W'(`HPP_DEASSERT_CYC);
  localparam logic [CNT_W-1:0] REASSERT_CYC = CNT_W'(`HPP_REASSERT_CYC);

  logic [5:0] raw_in;
  logic [5:0] syn;
  logic rd_line;
  logic wr_line;
  logic ds_line;
  logic ack_line;
  logic cs_ok;

  // polarity applied before sync so the core only sees active-high levels
  always_comb begin
    raw_in[0] = host_read_strobe ^ ~pol_strobe_high;
    raw_in[1] = host_write_strobe ^ ~pol_strobe_high;
    raw_in[2] = shared_data_strobe ^ ~pol_strobe_high;
    raw_in[3] = port_chip_selects[0] ^ ~pol_select_high;
    raw_in[4] = port_chip_selects[1] ^ ~pol_select_high;
    raw_in[5] = dma_acknowledge ^ ~pol_ack_high;
  end

  hpp_sync #(.WIDTH(6)) u_sync (
    .clk(clk),
    .srst(srst),
    .async_in(raw_in),
    .sync_out(syn)
  );

  logic [ADDR_W:0] addr_syn;
  logic rws_line;
  logic [ADDR_W-1:0] addr_line;

  // address and read/write ride the same two stages as the strobes, so a host
  // that lets them go just after strobe end cannot flip a strobe still in flight
  hpp_sync #(.WIDTH(ADDR_W + 1)) u_sync_addr (
    .clk(clk),
    .srst(srst),
    .async_in({read_write_select, port_address_lines}),
    .sync_out(addr_syn)
  );

  // both buses are stable around the strobe, so their skew settles before its edge
  always_comb begin
    rd_line = syn[0];
    wr_line = syn[1];
    ds_line = syn[2];
    ack_line = syn[5];
    cs_ok = syn[3] & syn[4];
    rws_line = addr_syn[ADDR_W];
    addr_line = addr_syn[ADDR_W-1:0];
  end

  logic rd_act;
  logic wr_act;
  logic rd_act_r;
  logic wr_act_r;
  logic ack_r;
  logic rd_end;
  logic wr_end;
  logic strobe_start;
  logic strobe_end;
  logic ack_start;
  logic ack_end;
  logic is_last;

  // strobe decode per strobe mode
  always_comb begin
    rd_act = dual_strobe_mode ? rd_line : (ds_line & rws_line);
    wr_act = dual_strobe_mode ? wr_line : (ds_line & ~rws_line);
    rd_act = rd_act & (cs_ok | dma_mode);
    wr_act = wr_act & (cs_ok | dma_mode);
    rd_end = rd_act_r & ~rd_act;
    wr_end = wr_act_r & ~wr_act;
    strobe_start = (rd_act & ~rd_act_r) | (wr_act & ~wr_act_r);
    strobe_end = rd_end | wr_end;
    ack_start = ack_line & ~ack_r;
    ack_end = ack_r & ~ack_line;
    is_last = mode_64bit && (addr_line == ADDR_W'(`HPP_LAST_ADDR));
  end

  // final location maps to word zero or three by byte order
  always_comb begin
    last_word_index = (byte_order_select == `HPP_BIG_END) ? `HPP_WORD_THREE
                                                        : `HPP_WORD_ZERO;
  end

  logic last_rd_r;
  logic last_rd_nxt;
  logic last_wr_r;
  logic last_wr_nxt;
  logic rd_done_r;
  logic rd_done_nxt;
  logic wr_done_r;
  logic wr_done_nxt;
  logic [CNT_W-1:0] hold_r;
  logic [CNT_W-1:0] hold_nxt;
  logic hold_act_r;
  logic hold_act_nxt;
  logic drop_r;
  logic drop_nxt;

  // last-register access tracking; request drop counted from strobe end
  always_comb begin
    last_rd_nxt = last_rd_r;
    last_wr_nxt = last_wr_r;
    rd_done_nxt = 1'b0;
    wr_done_nxt = 1'b0;
    hold_nxt = hold_r;
    hold_act_nxt = hold_act_r;
    drop_nxt = drop_r;
    if (rd_act & ~rd_act_r) begin
      last_rd_nxt = is_last;
    end
    if (wr_act & ~wr_act_r) begin
      last_wr_nxt = is_last;
    end
    // drop within the maximum delay; done one cycle after the synchronised end, up to three core periods after the pin end, just inside
    if ((rd_end & last_rd_r) | (wr_end & last_wr_r)) begin
      rd_done_nxt = rd_end & last_rd_r;
      wr_done_nxt = wr_end & last_wr_r;
      drop_nxt = 1'b1;
      hold_act_nxt = 1'b1;
      hold_nxt = '0;
    end else if (hold_act_r) begin
      if (hold_r < DEASSERT_CYC) begin
        hold_nxt = hold_r + CNT_W'(1);
      end else begin
        hold_act_nxt = 1'b0;
      end
    end
    // request may come back once the hold count from strobe end has run out
    if (drop_r & ~hold_act_r & ~((rd_end & last_rd_r) | (wr_end & last_wr_r))) begin
      drop_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      last_rd_r <= 1'b0;
      last_wr_r <= 1'b0;
      rd_done_r <= 1'b0;
      wr_done_r <= 1'b0;
      hold_r <= '0;
      hold_act_r <= 1'b0;
      drop_r <= 1'b0;
      rd_act_r <= 1'b0;
      wr_act_r <= 1'b0;
      ack_r <= 1'b0;
    end else begin
      last_rd_r <= last_rd_nxt;
      last_wr_r <= last_wr_nxt;
      rd_done_r <= rd_done_nxt;
      wr_done_r <= wr_done_nxt;
      hold_r <= hold_nxt;
      hold_act_r <= hold_act_nxt;
      drop_r <= drop_nxt;
      rd_act_r <= rd_act;
      wr_act_r <= wr_act;
      ack_r <= ack_line;
    end
  end

  hpp_pkg::hpp_dma_e dma_r;
  hpp_pkg::hpp_dma_e dma_nxt;
  logic [CNT_W-1:0] gap_r;
  logic [CNT_W-1:0] gap_nxt;
  logic qual_start;
  logic qual_end;

  // dma handshake: drop on qualifier start, return a least gap after its end
  always_comb begin
    qual_start = ack_qualifier_select ? strobe_start : ack_start;
    qual_end = ack_qualifier_select ? strobe_end : ack_end;
    dma_nxt = dma_r;
    gap_nxt = gap_r;
    unique case (dma_r)
      hpp_pkg::HPP_DMA_IDLE: begin
        if (dma_mode) begin
          dma_nxt = hpp_pkg::HPP_DMA_REQ;
        end
      end
      hpp_pkg::HPP_DMA_REQ: begin
        if (!dma_mode) begin
          dma_nxt = hpp_pkg::HPP_DMA_IDLE;
        end else if (qual_start) begin
          dma_nxt = hpp_pkg::HPP_DMA_BUSY;
        end
      end
      hpp_pkg::HPP_DMA_BUSY: begin
        if (qual_end) begin
          dma_nxt = hpp_pkg::HPP_DMA_GAP;
          gap_nxt = '0;
        end
      end
      hpp_pkg::HPP_DMA_GAP: begin
        // the gap keeps the reassertion from coming early
        if (gap_r + CNT_W'(1) >= REASSERT_CYC) begin
          dma_nxt = hpp_pkg::HPP_DMA_IDLE;
        end else begin
          gap_nxt = gap_r + CNT_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dma_r <= hpp_pkg::HPP_DMA_IDLE;
      gap_r <= '0;
    end else begin
      dma_r <= dma_nxt;
      gap_r <= gap_nxt;
    end
  end

  logic rx_req;
  logic tx_req;
  logic one_req;

  // request lines, level sensitive in double mode
  always_comb begin
    rx_req = (rx_data_ready | ~outgoing_fifo_empty) & ~drop_r;
    tx_req = (tx_space_ready | ~incoming_fifo_full) & ~drop_r;
    one_req = dma_mode ? (dma_r == hpp_pkg::HPP_DMA_REQ) : (rx_req | tx_req);
    combined_request = (double_request_mode ? 1'b0 : one_req) ^ ~pol_request_high;
    receive_request = (double_request_mode & rx_req) ^ ~pol_request_high;
    transmit_request = (double_request_mode & tx_req) ^ ~pol_request_high;
    last_read_done = rd_done_r;
    last_write_done = wr_done_r;
  end
endmodule

// [hpp_port_asserts.sv]
`timescale 1ns/1ps
// watches request lines, index and the read pulse output
module hpp_port_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic host_read_strobe,
  input wire logic shared_data_strobe,
  input wire logic read_write_select,
  input wire logic dma_acknowledge,
  input wire logic pol_strobe_high,
  input wire logic pol_ack_high,
  input wire logic pol_request_high,
  input wire logic dual_strobe_mode,
  input wire logic double_request_mode,
  input wire logic mode_64bit,
  input wire logic byte_order_select,
  input wire logic dma_mode,
  input wire logic ack_qualifier_select,
  input wire logic combined_request,
  input wire logic receive_request,
  input wire logic transmit_request,
  input wire logic [1:0] last_word_index,
  input wire logic last_read_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic rd_on, ack_on, off, dq;
  // pin levels folded through polarity so one property serves both
  assign rd_on = dual_strobe_mode ? host_read_strobe == pol_strobe_high
    : (shared_data_strobe == pol_strobe_high) && read_write_select;
  assign ack_on = dma_acknowledge == pol_ack_high;
  assign off = !pol_request_high;
  assign dq = dma_mode && !ack_qualifier_select && !double_request_mode;
  idx_map_a: assert property (last_word_index == (byte_order_select ? 2'h3 : 2'h0))
    else $error("last word index wrong");
  single_quiet_a: assert property (!double_request_mode |->
    receive_request == off && transmit_request == off) else $error("split request active");
  double_quiet_a: assert property (double_request_mode |-> combined_request == off)
    else $error("combined request active");
  rd_pulse_a: assert property (last_read_done |=> !last_read_done)
    else $error("read pulse too long");
  last_mode_a: assert property (last_read_done |-> mode_64bit)
    else $error("last read outside 64-bit mode");
  rd_hold_a: assert property (rd_on [*3] |-> !last_read_done)
    else $error("pulse while strobe held");
  dma_drop_a: assert property ((dq && ack_on) [*6] |-> combined_request == off)
    else $error("dma request not dropped");
  dma_gap_a: assert property ((dq && ack_on) [*4] ##1 (dq && !ack_on) |->
    (combined_request == off) [*3]) else $error("dma request back too soon");
  cover property (last_read_done);
  cover property (dq && ack_on);
  cover property (double_request_mode && receive_request == pol_request_high);
endmodule
bind hpp_port hpp_port_chk i_hpp_port_chk (.*);

// [hpp_host_model.sv]
`timescale 1ns/1ps
// host processor: selects, address, strobes and dma acknowledge
module hpp_host_model (
  input wire logic clk,
  input wire logic dual_strobe_mode,
  input wire logic pol_strobe_high,
  input wire logic pol_select_high,
  input wire logic pol_ack_high,
  output logic host_read_strobe,
  output logic host_write_strobe,
  output logic shared_data_strobe,
  output logic read_write_select = 1'b1,
  output logic [1:0] port_chip_selects,
  output logic [3:0] port_address_lines = 4'h0,
  output logic dma_acknowledge
);
  logic rd_act = 0, wr_act = 0, ds_act = 0, cs_act = 0, ack_act = 0;
  // pins follow polarity even while idle
  assign host_read_strobe = !(rd_act ^ pol_strobe_high);
  assign host_write_strobe = !(wr_act ^ pol_strobe_high);
  assign shared_data_strobe = !(ds_act ^ pol_strobe_high);
  assign port_chip_selects = {2{!(cs_act ^ pol_select_high)}};
  assign dma_acknowledge = !(ack_act ^ pol_ack_high);
  // one transfer; address is scrambled once released
  task xfer(input logic wr, input logic [3:0] a);
    @(posedge clk);
    cs_act <= 1'b1;
    port_address_lines <= a;
    read_write_select <= !wr;
    @(posedge clk);
    rd_act <= dual_strobe_mode && !wr;
    wr_act <= dual_strobe_mode && wr;
    ds_act <= !dual_strobe_mode;
    repeat (3) @(posedge clk);
    {rd_act, wr_act, ds_act} <= 3'h0;
    @(posedge clk);
    cs_act <= 1'b0;
    port_address_lines <= ~a;
    read_write_select <= wr;
    repeat (4) @(posedge clk);
  endtask
  task ack(input int n);
    @(posedge clk);
    ack_act <= 1'b1;
    repeat (n) @(posedge clk);
    ack_act <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule

// [tb_hpp_port.sv]
`timescale 1ns/1ps
module tb_hpp_port;
  logic clk = 0, srst = 1;
  logic host_read_strobe, host_write_strobe, shared_data_strobe, read_write_select;
  logic dma_acknowledge, combined_request, receive_request, transmit_request;
  logic [1:0] port_chip_selects, last_word_index;
  logic [3:0] port_address_lines;
  logic pol_strobe_high = 0, pol_select_high = 0, pol_ack_high = 0, pol_request_high = 0;
  logic dual_strobe_mode = 1, double_request_mode = 0, mode_64bit = 1;
  logic byte_order_select = 0, dma_mode = 0, ack_qualifier_select = 0;
  logic rx_data_ready = 1, tx_space_ready = 0, outgoing_fifo_empty = 1;
  logic incoming_fifo_full = 0, last_read_done, last_write_done;
  int n_fail = 0, comparisons = 0, n_rd = 0, n_wr = 0, n_off = 0, cyc = 0;
  hpp_port i_hpp_port (.*);
  hpp_host_model i_hpp_host_model (.*);
  always #2.5 clk = ~clk;
  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // pulse and drop tallies; the cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (last_read_done === 1'b1) n_rd <= n_rd + 1;
    if (last_write_done === 1'b1) n_wr <= n_wr + 1;
    if (combined_request !== pol_request_high) n_off <= n_off + 1;
    if (cyc == 3000) begin
      n_fail++;
      wrap_up;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    srst <= 0;
    for (int b = 0; b < 2; b++) begin
      @(posedge clk) byte_order_select <= b[0];
      @(posedge clk) #1 chk("index", b[0] ? 8'h03 : 8'h00, last_word_index);
    end
    $display("test index done");
    // both polarities, set on all lines together, with both strobe modes
    for (int p = 0; p < 2; p++) for (int d = 0; d < 2; d++) begin
      @(posedge clk) {pol_strobe_high, pol_select_high, pol_ack_high} <= {3{p[0]}};
      pol_request_high <= p[0];
      dual_strobe_mode <= d[0];
      repeat (8) @(posedge clk);
      #1 chk("request", p[0], combined_request);
      chk("rx request", !p[0], receive_request);
      {n_rd, n_off} = 0;
      i_hpp_host_model.xfer(0, 4'h3);
      #1 chk("plain read", 0, 8'(n_rd + n_off));
      i_hpp_host_model.xfer(0, 4'h7);
      repeat (8) @(posedge clk);
      #1 chk("last read", 1, 8'(n_rd));
      chk("read drop", 1, n_off != 0);
      chk("request back", p[0], combined_request);
      n_off = 0;
      i_hpp_host_model.xfer(1, 4'h7);
      repeat (8) @(posedge clk);
      #1 chk("last write", 1, 8'(n_wr));
      chk("write drop", 1, n_off != 0);
      n_wr = 0;
      $display("test strobes done");
    end
    // address seven outside 64-bit mode is an ordinary register
    {n_rd, n_off} = 0;
    @(posedge clk) mode_64bit <= 0;
    i_hpp_host_model.xfer(0, 4'h7);
    repeat (8) @(posedge clk);
    #1 chk("short read", 0, 8'(n_rd + n_off));
    @(posedge clk) mode_64bit <= 1;
    $display("test mode done");
    @(posedge clk) double_request_mode <= 1;
    repeat (4) @(posedge clk);
    #1 chk("split", 8'h03, {combined_request, receive_request, transmit_request});
    // transmit may drop once incoming is full; receive waits for outgoing empty
    @(posedge clk) incoming_fifo_full <= 1;
    rx_data_ready <= 0;
    outgoing_fifo_empty <= 0;
    @(posedge clk) #1 chk("split held", 8'h02, {combined_request, receive_request, transmit_request});
    @(posedge clk) outgoing_fifo_empty <= 1;
    @(posedge clk) #1 chk("split idle", 8'h00, {combined_request, receive_request, transmit_request});
    $display("test split done");
    @(posedge clk) double_request_mode <= 0;
    dma_mode <= 1;
    // acknowledge, then strobe, as the qualifier
    for (int q = 0; q < 2; q++) begin
      @(posedge clk) ack_qualifier_select <= q[0];
      repeat (8) @(posedge clk);
      n_off = 0;
      if (q == 0) i_hpp_host_model.ack(6);
      else i_hpp_host_model.xfer(0, 4'h0);
      repeat (8) @(posedge clk);
      #1 chk("dma drop", 1, n_off != 0);
      chk("dma back", 1, combined_request);
    end
    $display("test dma done");
    wrap_up;
  end
endmodule
